/* File: design/enc_pulse_pkg.sv */
// shared constants, types and helper functions for the encoder pulse output divider
package enc_pulse_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int PPR_W = 31;      // output pulse count setting, up to 2^30
    localparam int POS_W = 21;      // encoder counts and quadrature positions per turn
    localparam int SPEED_W = 13;    // motor speed magnitude in rev per minute
    localparam int GAP_W = 4;       // cycles since the last quadrature edge

    typedef logic [PPR_W-1:0] ppr_t;
    typedef logic [POS_W-1:0] pos_t;
    typedef logic [SPEED_W-1:0] speed_t;
    typedef logic [GAP_W-1:0] gap_t;

    ////////////////////////////////////////////////////////////////////////////////
    // output pulse count limits and granularity bands
    localparam ppr_t PPR_MIN = 31'h0000_0010;      // 16 pulses per turn
    localparam ppr_t PPR_DEFAULT = 31'h0000_0800;  // 2048 pulses per turn
    localparam ppr_t PPR_MAX_13 = 31'h0000_0800;   // 2048 for a 13-bit encoder
    localparam ppr_t PPR_MAX_17 = 31'h0000_8000;   // 32768 for a 17-bit encoder
    localparam ppr_t PPR_MAX_20 = 31'h0004_0000;   // 262144 for a 20-bit encoder
    localparam ppr_t BAND1_MAX = 31'h0000_4000;    // step 1 up to 16384
    localparam ppr_t BAND2_MAX = 31'h0000_8000;    // step 2 up to 32768
    localparam ppr_t BAND3_MAX = 31'h0001_0000;    // step 4 up to 65536
    localparam ppr_t BAND4_MAX = 31'h0002_0000;    // step 8 up to 131072

    // encoder counts per turn
    localparam pos_t RES_13 = 21'h00_2000;
    localparam pos_t RES_17 = 21'h02_0000;
    localparam pos_t RES_20 = 21'h10_0000;

    // speed limit of the finest band, halved for each coarser band
    localparam speed_t SPEED_LIMIT_BASE = 13'h1770;    // 6000 per minute

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int MAX_PULSE_PPS = 1_600_000;
    localparam int EDGES_PER_PULSE = 4;
    // least spacing of quadrature edges, rounded up to whole cycles
    localparam int MIN_EDGE_GAP_CYC = (CLK_HZ + EDGES_PER_PULSE * MAX_PULSE_PPS - 1)
                                      / (EDGES_PER_PULSE * MAX_PULSE_PPS);
    localparam gap_t MIN_EDGE_GAP = GAP_W'(MIN_EDGE_GAP_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // quadrature phase fields of the position counter
    localparam int QBIT_HI = 1;
    localparam int QBIT_LO = 0;
    localparam pos_t INDEX_ZONE = 21'h00_0002;     // one phase A high time
    localparam pos_t POS_ONE = 21'h00_0001;
    localparam pos_t POS_ZERO = 21'h00_0000;
    localparam gap_t GAP_ONE = 4'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // enumerations
    typedef enum logic [1:0] {
        RES_SEL_13 = 2'b00,
        RES_SEL_17 = 2'b01,
        RES_SEL_20 = 2'b10
    } res_sel_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN = 2'b01,
        ST_FAULT = 2'b10
    } ctl_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    // granularity band as a power of two
    function automatic logic [2:0] step_shift(input ppr_t ppr);
        if (ppr <= BAND1_MAX) return 3'h0;
        else if (ppr <= BAND2_MAX) return 3'h1;
        else if (ppr <= BAND3_MAX) return 3'h2;
        else if (ppr <= BAND4_MAX) return 3'h3;
        else return 3'h4;
    endfunction

    // largest setting the encoder allows; zero for an unknown encoder
    function automatic ppr_t ppr_max(input logic [1:0] sel);
        case (sel)
            RES_SEL_13: return PPR_MAX_13;
            RES_SEL_17: return PPR_MAX_17;
            RES_SEL_20: return PPR_MAX_20;
            default: return '0;
        endcase
    endfunction

    function automatic pos_t res_count(input logic [1:0] sel);
        case (sel)
            RES_SEL_13: return RES_13;
            RES_SEL_17: return RES_17;
            default: return RES_20;
        endcase
    endfunction

    function automatic logic ppr_valid(input ppr_t ppr, input logic [1:0] sel);
        ppr_t mask;
        mask = (ppr_t'(1) << step_shift(ppr)) - ppr_t'(1);
        return (ppr >= PPR_MIN) && (ppr <= ppr_max(sel)) && ((ppr & mask) == '0);
    endfunction

    function automatic speed_t speed_limit(input ppr_t ppr);
        return SPEED_LIMIT_BASE >> step_shift(ppr);
    endfunction

endpackage

/* File: design/quad_phase_stage.sv */
// quadrature and index output stage driven by single quadrature steps
`timescale 1ns/1ps
module quad_phase_stage
    import enc_pulse_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic step,
    input wire logic dir_fwd,
    input wire pos_t quad_total,
    output logic out_a,
    output logic out_a_n,
    output logic out_b,
    output logic out_b_n,
    output logic out_idx,
    output logic out_idx_n
);

    pos_t qpos;     // quadrature position within one turn
    pos_t next_qpos;
    logic next_a, next_b, next_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // next position and phase levels
    always_comb begin
        next_qpos = qpos;
        if (step) begin
            // wrap at four edges per output pulse times the pulse count
            if (dir_fwd) begin
                next_qpos = (qpos == quad_total - POS_ONE) ? POS_ZERO : qpos + POS_ONE;
            end else begin
                next_qpos = (qpos == POS_ZERO) ? quad_total - POS_ONE : qpos - POS_ONE;
            end
        end
        // RQ1 gray sequence, 90 degrees
        // a leads b by one edge; only one bit of the gray pair moves per step
        next_a = ~next_qpos[QBIT_HI];
        next_b = next_qpos[QBIT_HI] ^ next_qpos[QBIT_LO];
        // RQ3 index at origin
        // RQ4 index width equals a high
        next_idx = next_qpos < INDEX_ZONE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; the complement pins come from their own flops for equal delay
    always_ff @(posedge clk) begin
        if (srst) begin
            qpos <= POS_ZERO;
            out_a <= 1'b1;
            out_a_n <= 1'b0;
            out_b <= 1'b0;
            out_b_n <= 1'b1;
            out_idx <= 1'b1;
            out_idx_n <= 1'b0;
        end else begin
            qpos <= next_qpos;
            out_a <= next_a;
            out_a_n <= ~next_a;
            out_b <= next_b;
            out_b_n <= ~next_b;
            out_idx <= next_idx;
            out_idx_n <= ~next_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_one_phase_edge;
        !($changed(out_a) && $changed(out_b));
    endproperty
    a_one_phase_edge: assert property (p_one_phase_edge) else $error("a and b together"); // RQ1

    property p_index_at_origin;
        $rose(out_idx) |-> (qpos == POS_ZERO) || (qpos == POS_ONE);
    endproperty
    a_index_at_origin: assert property (p_index_at_origin) else $error("index off origin"); // RQ3

    property p_index_in_a;
        out_idx |-> out_a && !out_idx_n;
    endproperty
    a_index_in_a: assert property (p_index_in_a) else $error("index outside a high"); // RQ4

    cover_index_rise: cover property (step && dir_fwd ##1 $rose(out_idx));

endmodule // quad_phase_stage

/* File: design/encoder_pulse_output_divider.sv */
// encoder pulse output divider: setting check, pulse division and rate alarms
// Requirements on this block and its host
// RQ1 - phase a and b quadrature, 90 degrees
// RQ2 - pulses per turn equal configured count
// RQ3 - one index pulse per turn
// RQ4 - index width equals one phase a pulse
// RQ5 - reverse rotation keeps same phase form
// RQ6 - divide encoder counts per turn internally
// RQ7 - granularity steps of 1,2,4,8,16 by band
// RQ8 - maximum count depends on encoder resolution
// RQ9 - setting alarm on range or step violation
// RQ10 - speed limit falls as count grows
// RQ11 - overspeed alarm above speed limit
// RQ12 - output pulse rate at most 1.6 Mpps; faster edges still pass and only raise OVERSPEED_ALARM
// RQ13 - host turns motor twice before origin return
// RQ14 - setting sampled only when leaving reset
`timescale 1ns/1ps
module encoder_pulse_output_divider
    import enc_pulse_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic ENC_STEP,
    input wire logic ENC_DIR,
    input wire logic [1:0] ENC_RES_SEL,
    input wire ppr_t OUTPUT_PULSES_PER_REV,
    input wire logic REVERSE_ROTATION_SELECT,
    input wire speed_t MOTOR_SPEED,
    output logic QUAD_OUT_A,
    output logic QUAD_OUT_A_N,
    output logic QUAD_OUT_B,
    output logic QUAD_OUT_B_N,
    output logic INDEX_OUT,
    output logic INDEX_OUT_N,
    output logic SETTING_ALARM,
    output logic OVERSPEED_ALARM
);

    ////////////////////////////////////////////////////////////////////////////////
    // configuration captured once after reset
    ctl_state_t state;              // load, run or fault
    ctl_state_t next_state;
    ppr_t cfg_ppr;                  // accepted output pulse count
    ppr_t next_cfg_ppr;
    pos_t cfg_res;                  // encoder counts per turn
    pos_t next_cfg_res;
    pos_t cfg_quad_total;           // quadrature edges per turn, four per pulse
    pos_t next_cfg_quad_total;
    speed_t cfg_speed_limit;        // allowed speed for this count
    speed_t next_cfg_speed_limit;
    logic cfg_reverse;              // held for reference only, never steers the outputs
    logic next_cfg_reverse;
    logic next_setting_alarm;

    // next values of the configuration and the setting alarm
    always_comb begin
        next_state = state;
        next_cfg_ppr = cfg_ppr;
        next_cfg_res = cfg_res;
        next_cfg_quad_total = cfg_quad_total;
        next_cfg_speed_limit = cfg_speed_limit;
        next_cfg_reverse = cfg_reverse;
        next_setting_alarm = SETTING_ALARM;
        unique case (state)
            ST_LOAD: begin
                // RQ14 sample once
                // later changes on the setting pins wait for the next reset
                next_cfg_ppr = OUTPUT_PULSES_PER_REV;
                next_cfg_res = res_count(ENC_RES_SEL);
                next_cfg_quad_total = pos_t'({OUTPUT_PULSES_PER_REV, 2'b00});
                // RQ10 speed limit by band
                next_cfg_speed_limit = speed_limit(OUTPUT_PULSES_PER_REV);
                next_cfg_reverse = REVERSE_ROTATION_SELECT;
                // RQ7 granularity check
                // RQ8 resolution maximum
                // RQ9 setting alarm
                if (ppr_valid(OUTPUT_PULSES_PER_REV, ENC_RES_SEL)) begin
                    next_state = ST_RUN;
                end else begin
                    next_state = ST_FAULT;
                    next_setting_alarm = 1'b1;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            ST_FAULT: begin
                // outputs stay frozen until the next reset
                next_state = ST_FAULT;
            end
            default: begin
                next_state = ST_FAULT;
            end
        endcase
    end

    // configuration registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= ST_LOAD;
            cfg_ppr <= PPR_DEFAULT;
            cfg_res <= RES_13;
            cfg_quad_total <= pos_t'({PPR_DEFAULT, 2'b00});
            cfg_speed_limit <= SPEED_LIMIT_BASE;
            cfg_reverse <= 1'b0;
            SETTING_ALARM <= 1'b0;
        end else begin
            state <= next_state;
            cfg_ppr <= next_cfg_ppr;
            cfg_res <= next_cfg_res;
            cfg_quad_total <= next_cfg_quad_total;
            cfg_speed_limit <= next_cfg_speed_limit;
            cfg_reverse <= next_cfg_reverse;
            SETTING_ALARM <= next_setting_alarm;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // division of encoder counts into quadrature edges
    pos_t acc;                      // fractional position, always below cfg_res
    pos_t next_acc;
    logic quad_step;                // one quadrature edge this cycle
    logic next_quad_step;
    logic quad_dir;                 // edge direction, high for forward
    logic next_quad_dir;
    pos_t sum_fwd;                  // acc plus one encoder count worth of edges
    logic run_step;

    // next accumulator and edge request
    always_comb begin
        next_acc = acc;
        next_quad_step = 1'b0;
        next_quad_dir = quad_dir;
        sum_fwd = acc + cfg_quad_total;
        run_step = (state == ST_RUN) && ENC_STEP;
        // RQ6 divide encoder counts
        // a valid setting keeps four times the count at or below the resolution,
        // so one encoder count never yields more than one quadrature edge
        if (run_step) begin
            next_quad_dir = ENC_DIR;
            // RQ5 direction untouched
            if (ENC_DIR) begin
                if (sum_fwd >= cfg_res) begin
                    next_acc = sum_fwd - cfg_res;
                    next_quad_step = 1'b1;
                end else begin
                    next_acc = sum_fwd;
                end
            end else begin
                if (acc < cfg_quad_total) begin
                    next_acc = acc + (cfg_res - cfg_quad_total);
                    next_quad_step = 1'b1;
                end else begin
                    next_acc = acc - cfg_quad_total;
                end
            end
        end
    end

    // accumulator registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            acc <= POS_ZERO;
            quad_step <= 1'b0;
            quad_dir <= 1'b1;
        end else begin
            acc <= next_acc;
            quad_step <= next_quad_step;
            quad_dir <= next_quad_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // overspeed supervision: motor speed and edge spacing
    gap_t gap_cnt;                  // cycles since the last edge, saturating
    gap_t next_gap_cnt;
    logic next_overspeed;
    logic gap_short;                // edge closer than the pulse rate allows

    // next gap count and sticky overspeed alarm
    always_comb begin
        next_gap_cnt = (gap_cnt < MIN_EDGE_GAP) ? gap_cnt + GAP_ONE : gap_cnt;
        gap_short = next_quad_step && (gap_cnt < MIN_EDGE_GAP);
        next_overspeed = OVERSPEED_ALARM;
        if (next_quad_step) begin
            next_gap_cnt = GAP_ONE;
        end
        // RQ11 speed above limit
        // RQ12 edge rate ceiling
        // edges are still passed on; the alarm tells the host they may be unreliable
        if ((state == ST_RUN) && ((MOTOR_SPEED > cfg_speed_limit) || gap_short)) begin
            next_overspeed = 1'b1;
        end
    end

    // supervision registers; the alarm only clears by reset
    always_ff @(posedge CLK) begin
        if (SRST) begin
            gap_cnt <= MIN_EDGE_GAP;
            OVERSPEED_ALARM <= 1'b0;
        end else begin
            gap_cnt <= next_gap_cnt;
            OVERSPEED_ALARM <= next_overspeed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output stage
    // RQ2 count per turn
    // RQ3 index per turn
    quad_phase_stage u_stage (
        .clk(CLK),
        .srst(SRST),
        .step(quad_step),
        .dir_fwd(quad_dir),
        .quad_total(cfg_quad_total),
        .out_a(QUAD_OUT_A),
        .out_a_n(QUAD_OUT_A_N),
        .out_b(QUAD_OUT_B),
        .out_b_n(QUAD_OUT_B_N),
        .out_idx(INDEX_OUT),
        .out_idx_n(INDEX_OUT_N)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_complement;
        (QUAD_OUT_A_N == !QUAD_OUT_A) && (QUAD_OUT_B_N == !QUAD_OUT_B);
    endproperty
    a_complement: assert property (p_complement) else $error("complement pins disagree"); // RQ1

    property p_step_follows_enc;
        $changed(QUAD_OUT_A) || $changed(QUAD_OUT_B)
        |-> $past(ENC_STEP, 2) && $past(state, 2) == ST_RUN;
    endproperty
    a_step_follows_enc: assert property (p_step_follows_enc) else $error("edge no count"); // RQ2

    property p_reverse_no_effect;
        $changed(REVERSE_ROTATION_SELECT) && !ENC_STEP ##1 !ENC_STEP
        |=> $stable(QUAD_OUT_A) && $stable(QUAD_OUT_B);
    endproperty
    a_reverse_no_effect: assert property (p_reverse_no_effect) else $error("reverse moved"); // RQ5

    property p_acc_range;
        state == ST_RUN |-> acc < cfg_res;
    endproperty
    a_acc_range: assert property (p_acc_range) else $error("divider out of range"); // RQ6

    property p_odd_high_band;
        state == ST_LOAD && OUTPUT_PULSES_PER_REV > BAND1_MAX
        && OUTPUT_PULSES_PER_REV[0] |=> SETTING_ALARM;
    endproperty
    a_odd_high_band: assert property (p_odd_high_band) else $error("odd count taken"); // RQ7

    property p_over_max_13;
        state == ST_LOAD && ENC_RES_SEL == RES_SEL_13 && OUTPUT_PULSES_PER_REV > PPR_MAX_13
        |=> SETTING_ALARM && state == ST_FAULT;
    endproperty
    a_over_max_13: assert property (p_over_max_13) else $error("13-bit maximum exceeded"); // RQ8

    property p_setting_alarm;
        state == ST_LOAD |=> SETTING_ALARM == (state == ST_FAULT);
    endproperty
    a_setting_alarm: assert property (p_setting_alarm) else $error("setting alarm wrong"); // RQ9

    property p_top_band_limit;
        state == ST_RUN && cfg_ppr > BAND4_MAX |-> cfg_speed_limit == (SPEED_LIMIT_BASE >> 4);
    endproperty
    a_top_band_limit: assert property (p_top_band_limit) else $error("top band limit"); // RQ10

    property p_overspeed;
        state == ST_RUN && MOTOR_SPEED > cfg_speed_limit |=> OVERSPEED_ALARM;
    endproperty
    a_overspeed: assert property (p_overspeed) else $error("overspeed not flagged"); // RQ11

    // two edges six cycles apart break the pulse rate ceiling
    property p_edge_gap;
        quad_step ##1 (!quad_step) [*5] ##1 quad_step |=> OVERSPEED_ALARM;
    endproperty
    a_edge_gap: assert property (p_edge_gap) else $error("fast edges not flagged"); // RQ12

    property p_cfg_frozen;
        state != ST_LOAD |=> $stable(cfg_ppr) && $stable(cfg_res);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("setting changed after load"); // RQ14

    // the reverse mode is latched with the count but never steers anything
    property p_rev_latched;
        state == ST_LOAD |=> cfg_reverse == $past(REVERSE_ROTATION_SELECT);
    endproperty
    a_rev_latched: assert property (p_rev_latched) else $error("reverse not latched"); // RQ14

    property p_set_sticky;
        SETTING_ALARM |=> SETTING_ALARM;
    endproperty
    a_set_sticky: assert property (p_set_sticky) else $error("setting alarm dropped"); // RQ9

    // a refused setting leaves the phase pins at their reset levels
    property p_fault_frozen;
        state == ST_FAULT |-> QUAD_OUT_A && !QUAD_OUT_B && INDEX_OUT;
    endproperty
    a_fault_frozen: assert property (p_fault_frozen) else $error("pins moved in fault"); // RQ9

    property p_ovs_sticky;
        OVERSPEED_ALARM |=> OVERSPEED_ALARM;
    endproperty
    a_ovs_sticky: assert property (p_ovs_sticky) else $error("overspeed dropped"); // RQ11

    cover_run_fwd: cover property (state == ST_RUN && ENC_STEP && ENC_DIR
        ##2 $changed(QUAD_OUT_A));
    cover_run_rev: cover property (state == ST_RUN && ENC_STEP && !ENC_DIR
        ##2 $changed(QUAD_OUT_B));
    cover_setting_fault: cover property ($rose(SETTING_ALARM));
    cover_overspeed: cover property ($rose(OVERSPEED_ALARM));

endmodule // encoder_pulse_output_divider

/* File: testbench/host_pulse_monitor.sv */
// host side model: decodes the quadrature feedback and counts pulses
`timescale 1ns/1ps
module host_pulse_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic qa,
    input wire logic qa_n,
    input wire logic qb,
    input wire logic qb_n,
    input wire logic idx,
    input wire logic idx_n,
    output int pos,
    output int a_rises,
    output int idx_rises,
    output int a_len,
    output int idx_len,
    output int phase_errs
);
    logic pa, pb, pi; // last samples
    int ia, ii; // running high times in cycles
    logic [1:0] dq; // quadrature step between samples

    ////////////////////////////////////////////////////////////////////////////////
    // sample just after the edge so the registered outputs have settled
    always @(posedge clk) begin
        #1;
        dq = {~qa, qa ~^ qb} - {~pa, pa ~^ pb};
        if (srst) begin
            pos = 0;
            a_rises = 0;
            idx_rises = 0;
            phase_errs = 0;
            ia = 0;
            ii = 0;
        end else begin
            // a jump of two phase steps means both lines moved together
            if (dq == 2'h1) begin
                pos++;
            end else if (dq == 2'h3) begin
                pos--;
            end else if (dq == 2'h2) begin
                phase_errs++;
            end
            // complement pins must mirror their partners
            if ({qa_n, qb_n, idx_n} !== ~{qa, qb, idx}) begin
                phase_errs++;
            end
            a_rises += int'(qa && !pa);
            idx_rises += int'(idx && !pi);
            if (qa) begin
                ia++;
            end else if (pa) begin
                a_len = ia;
                ia = 0;
            end
            if (idx) begin
                ii++;
            end else if (pi) begin
                idx_len = ii;
                ii = 0;
            end
        end
        pa = qa;
        pb = qb;
        pi = idx;
    end
endmodule // host_pulse_monitor

/* File: testbench/tb_top.sv */
// self-checking bench for the encoder pulse output divider
`timescale 1ns/1ps
module tb_top import enc_pulse_pkg::*;;
    ////////////////////////////////////////////////////////////////////////////////
    // signals
    logic clk, srst, enc_step, enc_dir, rev_sel; // driven at the falling edge
    logic [1:0] res_sel; // encoder resolution code
    ppr_t ppr; // pulses per turn
    speed_t speed; // motor speed
    logic qa, qa_n, qb, qb_n, idx, idx_n, set_alm, ovs_alm;
    int failures, n_compared, cycles;
    int pos, a_rises, idx_rises, a_len, idx_len, phase_errs; // host model view

    encoder_pulse_output_divider i_encoder_pulse_output_divider (
        .CLK(clk), .SRST(srst), .ENC_STEP(enc_step), .ENC_DIR(enc_dir),
        .ENC_RES_SEL(res_sel), .OUTPUT_PULSES_PER_REV(ppr),
        .REVERSE_ROTATION_SELECT(rev_sel), .MOTOR_SPEED(speed),
        .QUAD_OUT_A(qa), .QUAD_OUT_A_N(qa_n), .QUAD_OUT_B(qb), .QUAD_OUT_B_N(qb_n),
        .INDEX_OUT(idx), .INDEX_OUT_N(idx_n), .SETTING_ALARM(set_alm),
        .OVERSPEED_ALARM(ovs_alm));

    host_pulse_monitor i_host_pulse_monitor (
        .clk(clk), .srst(srst), .qa(qa), .qa_n(qa_n), .qb(qb), .qb_n(qb_n),
        .idx(idx), .idx_n(idx_n), .pos(pos), .a_rises(a_rises),
        .idx_rises(idx_rises), .a_len(a_len), .idx_len(idx_len),
        .phase_errs(phase_errs));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the run needs about 35000 cycles
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic cmp_bits(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic cmp_int(input int got, input int exp, input string m);
        n_compared++;
        if (got != exp) begin
            failures++;
            $display("[FAIL] %0t %s got %0d want %0d", $time, m, got, exp);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // setting is only sampled on release, so every new setting needs a reset
    task automatic restart(input ppr_t p, input logic [1:0] r);
        srst = 1'b1;
        ppr = p;
        res_sel = r;
        speed = '0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // n counts, one every gap cycles, then let the two-stage pipe drain
    task automatic steps(input int n, input logic d, input int gap);
        repeat (n) begin
            enc_step = 1'b1;
            enc_dir = d;
            @(negedge clk);
            if (gap > 1) begin
                enc_step = 1'b0;
                repeat (gap - 1) @(negedge clk);
            end
        end
        enc_step = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic cfg(input ppr_t p, input logic [1:0] r, input speed_t s, input logic [1:0] e);
        restart(p, r);
        speed = s;
        repeat (3) @(negedge clk);
        cmp_bits({6'h00, set_alm, ovs_alm}, {6'h00, e}, "alarms");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_levels;
        repeat (3) @(negedge clk);
        cmp_bits({qa, qa_n, qb, qb_n, idx, idx_n, set_alm, ovs_alm}, 8'h98, "reset");
    endtask
    task automatic t_settings;
        cfg(31'h0000_0010, 2'b00, 13'h1770, 2'b00);
        cfg(31'h0000_000f, 2'b00, 13'h0000, 2'b10);
        cfg(31'h0000_0800, 2'b00, 13'h1771, 2'b01);
        cfg(31'h0000_0801, 2'b00, 13'h0000, 2'b10);
        cfg(31'h0000_61a8, 2'b01, 13'h0bb8, 2'b00);
        cfg(31'h0000_61a9, 2'b01, 13'h0000, 2'b10);
        cfg(31'h0000_4002, 2'b10, 13'h0bb9, 2'b01);
        cfg(31'h0000_8002, 2'b10, 13'h0000, 2'b10);
        cfg(31'h0001_0008, 2'b10, 13'h02ee, 2'b00);
        cfg(31'h0002_0010, 2'b10, 13'h0177, 2'b00);
        cfg(31'h0004_0000, 2'b10, 13'h0178, 2'b01);
        cfg(31'h0004_0010, 2'b10, 13'h0000, 2'b10);
        cfg(31'h0000_0800, 2'b11, 13'h0000, 2'b10);
        // a bad value written while running must stay unseen
        restart(PPR_DEFAULT, 2'b00);
        ppr = 31'h0000_0001;
        repeat (3) @(negedge clk);
        cmp_bits({7'h00, set_alm}, 8'h00, "late change");
    endtask
    task automatic t_turns;
        // 16 pulses on 8192 counts: one edge per 128 counts
        restart(31'h0000_0010, 2'b00);
        rev_sel = 1'b0;
        steps(16768, 1'b1, 1);
        cmp_int(pos, 131, "fwd edges");
        cmp_int(a_rises, 32, "fwd pulses");
        cmp_int(idx_rises, 2, "fwd index");
        cmp_int(a_len, 256, "a high");
        cmp_int(idx_len, 256, "index width");
        rev_sel = 1'b1;
        repeat (2) @(negedge clk);
        steps(16768, 1'b0, 1);
        cmp_int(pos, 0, "back edges");
        cmp_int(a_rises, 65, "back pulses");
        cmp_int(idx_rises, 5, "back index");
        cmp_int(idx_len, 256, "back width");
        cmp_int(phase_errs, 0, "phase form");
        cmp_bits({6'h00, set_alm, ovs_alm}, 8'h00, "turn alarms");
        rev_sel = 1'b0;
    endtask
    task automatic t_rate;
        // 2048 pulses on 8192 counts: every count is an edge
        restart(31'h0000_0800, 2'b00);
        steps(40, 1'b1, 7);
        cmp_bits({7'h00, ovs_alm}, 8'h00, "7 cycle gap");
        steps(8, 1'b1, 6);
        cmp_bits({7'h00, ovs_alm}, 8'h01, "6 cycle gap");
    endtask

    initial begin
        srst = 1'b1;
        enc_step = 1'b0;
        enc_dir = 1'b1;
        rev_sel = 1'b0;
        res_sel = 2'b00;
        ppr = PPR_DEFAULT;
        speed = '0;
        t_reset_levels();
        t_settings();
        t_turns();
        t_rate();
        stop_test();
    end
endmodule // tb_top
